/* thl_pkg.sv */
// Package of constants for the thermal health log counters
package thl_pkg;

	// ----------------------------------------
	// Log page byte offsets
	// ----------------------------------------
	localparam logic [8:0] SENSOR3_OFS = 9'h0cc;
	localparam logic [8:0] SENSOR8_END = 9'h0d7;
	localparam logic [8:0] TMT1_COUNT_OFS = 9'h0d8;
	localparam logic [8:0] TMT2_COUNT_OFS = 9'h0dc;
	localparam logic [8:0] TMT1_TIME_OFS = 9'h0e0;
	localparam logic [8:0] TMT2_TIME_OFS = 9'h0e4;
	localparam logic [8:0] FIELD_END = 9'h0e7;

	// ----------------------------------------
	// Widths and reset values
	// ----------------------------------------
	localparam int SENSOR_COUNT = 6;
	localparam int SENSOR_WIDTH = 16;
	localparam int COUNT_WIDTH = 32;
	localparam logic [31:0] COUNT_MAX = 32'hffffffff;
	localparam logic [31:0] COUNT_RESET = 32'h00000000;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLOCK_HZ = 50000000;
	localparam int SECOND_S = 1;
	localparam int SECOND_CYCLES = CLOCK_HZ * SECOND_S;
	localparam logic [25:0] SECOND_LAST = 26'(SECOND_CYCLES - 1);

endpackage : thl_pkg

/* thl_sat_counter.sv */
// Saturating 32-bit counter
`timescale 1ns/1ns
module thl_sat_counter
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic enable,
	input wire logic countUp,
	output logic [thl_pkg::COUNT_WIDTH-1:0] count
);
	import thl_pkg::*;

	logic [COUNT_WIDTH-1:0] count_reg;
	logic [COUNT_WIDTH-1:0] count_next;

	always_comb
	begin
		count_next = count_reg;
		// Disabled counter is forced to zero
		if (!enable)
			count_next = COUNT_RESET; // RQ7
		else if (countUp && count_reg != COUNT_MAX) // RQ6
			count_next = count_reg + 32'h00000001;
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			count_reg <= COUNT_RESET; // RQ7
		else
			count_reg <= count_next;
	end

	assign count = count_reg;

endmodule : thl_sat_counter

/* thl_log_counters.sv */
// Thermal tail of the health log page: sensors, transition and time counters
`timescale 1ns/1ns

// What this block does
// RQ1: Sensors three to eight appear as little-endian 16-bit fields at bytes 204 to 215.
// RQ2: Each rise above the first threshold adds one to the count at bytes 216 to 219.
// RQ3: Each rise above the second threshold adds one to the count at bytes 220 to 223.
// RQ4: Seconds spent in first-threshold mitigation add up at bytes 224 to 227.
// RQ5: Seconds spent in second-threshold throttling add up at bytes 228 to 231.
// RQ6: All four counters stop at all ones and never wrap.
// RQ7: A counter reads zero until its event occurs, and always when not implemented.
// RQ8: Sensor fields carry kelvin, and an absent sensor reads zero.
// RQ9: Bytes 232 to 511 of the page always read zero.
module thl_log_counters
#(
	// Shorter tick lets a bench reach the time counters; default is one second
	parameter logic [25:0] TICK_LAST = thl_pkg::SECOND_LAST
)
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [95:0] sensorKelvin,
	input wire logic [5:0] sensorPresent,
	input wire logic counterEnable,
	input wire logic tmt1Active,
	input wire logic tmt2Active,
	input wire logic readStrobe,
	input wire logic [8:0] readByteAddr,
	output logic [7:0] readData,
	output logic readValid
);
	import thl_pkg::*;

	// ----------------------------------------
	// Sensor fields
	// ----------------------------------------
	logic [95:0] sensorField;

	genvar gi;
	generate
		for (gi = 0; gi < SENSOR_COUNT; gi++)
		begin : g_sensor
			// Absent sensor reports zero kelvin
			assign sensorField[gi*16 +: 16] = sensorPresent[gi] ?
				sensorKelvin[gi*16 +: 16] : 16'h0000; // RQ8
		end
	endgenerate

	// ----------------------------------------
	// Entry edge detect
	// ----------------------------------------
	logic tmt1Prev_reg;
	logic tmt1Prev_next;
	logic tmt2Prev_reg;
	logic tmt2Prev_next;
	logic tmt1Rise;
	logic tmt2Rise;

	always_comb
	begin
		tmt1Prev_next = tmt1Active;
		tmt2Prev_next = tmt2Active;
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			tmt1Prev_reg <= 1'b0;
			tmt2Prev_reg <= 1'b0;
		end
		else
		begin
			tmt1Prev_reg <= tmt1Prev_next;
			tmt2Prev_reg <= tmt2Prev_next;
		end
	end

	// Count entries only, so a long mitigation spell counts once
	// Low after reset, so a level already high at release is an entry
	assign tmt1Rise = tmt1Active && !tmt1Prev_reg; // RQ2
	assign tmt2Rise = tmt2Active && !tmt2Prev_reg; // RQ3

	// ----------------------------------------
	// One-second tick
	// ----------------------------------------
	logic [25:0] tick_reg;
	logic [25:0] tick_next;
	logic secondTick;

	always_comb
	begin
		tick_next = (tick_reg == TICK_LAST) ? 26'h0000000 : tick_reg + 26'h0000001;
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			tick_reg <= 26'h0000000;
		else
			tick_reg <= tick_next;
	end

	assign secondTick = (tick_reg == TICK_LAST);

	// ----------------------------------------
	// Counters
	// ----------------------------------------
	logic [31:0] tmt1Count;
	logic [31:0] tmt2Count;
	logic [31:0] tmt1Time;
	logic [31:0] tmt2Time;
	logic tmt1Second;
	logic tmt2Second;

	// Clearing on disable wins over an event in the same cycle
	assign tmt1Second = tmt1Active && secondTick; // RQ4
	assign tmt2Second = tmt2Active && secondTick; // RQ5

	thl_sat_counter u_tmt1Count (
		.ref_clk(ref_clk),
		.srst(srst),
		.enable(counterEnable),
		.countUp(tmt1Rise), // RQ2
		.count(tmt1Count)
	);

	thl_sat_counter u_tmt2Count (
		.ref_clk(ref_clk),
		.srst(srst),
		.enable(counterEnable),
		.countUp(tmt2Rise), // RQ3
		.count(tmt2Count)
	);

	// A partial second counts only if a tick falls inside it: time advances on the free-running tick
	thl_sat_counter u_tmt1Time (
		.ref_clk(ref_clk),
		.srst(srst),
		.enable(counterEnable),
		.countUp(tmt1Second), // RQ4
		.count(tmt1Time)
	);

	thl_sat_counter u_tmt2Time (
		.ref_clk(ref_clk),
		.srst(srst),
		.enable(counterEnable),
		.countUp(tmt2Second), // RQ5
		.count(tmt2Time)
	);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	logic inSensor;
	logic inCounter;
	logic inReserved;
	logic [8:0] rel;
	logic [3:0] sensorByte;
	logic [1:0] counterSel;
	logic [1:0] byteSel;

	always_comb
	begin
		rel = readByteAddr - SENSOR3_OFS;
		inSensor = (readByteAddr >= SENSOR3_OFS) && (readByteAddr <= SENSOR8_END);
		inCounter = (readByteAddr >= TMT1_COUNT_OFS) && (readByteAddr <= FIELD_END);
		inReserved = !inSensor && !inCounter;
		sensorByte = rel[3:0];
		// Counter words sit on four-byte boundaries, so low address bits pick the field
		counterSel = readByteAddr[3:2];
		byteSel = readByteAddr[1:0];
	end

	// ----------------------------------------
	// Log page read port
	// ----------------------------------------
	logic [7:0] readData_reg;
	logic [7:0] readData_next;
	logic readValid_reg;
	logic readValid_next;
	logic [31:0] counterWord;

	always_comb
	begin
		// Every request is answered, so the host never waits on a refusal
		readValid_next = readStrobe;
		readData_next = readData_reg;
		counterWord = COUNT_RESET;
		case (counterSel)
			2'h2: counterWord = tmt1Count; // RQ2
			2'h3: counterWord = tmt2Count; // RQ3
			2'h0: counterWord = tmt1Time; // RQ4
			2'h1: counterWord = tmt2Time; // RQ5
			default: counterWord = COUNT_RESET;
		endcase
		if (readStrobe)
		begin
			// No snapshot: a counter may move between byte reads of one field
			readData_next = ZERO_BYTE;
			if (inSensor)
				readData_next = sensorField[sensorByte*8 +: 8]; // RQ1
			if (inCounter)
				readData_next = counterWord[byteSel*8 +: 8];
			if (inReserved)
				readData_next = ZERO_BYTE; // RQ9
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			readData_reg <= ZERO_BYTE;
			readValid_reg <= 1'b0;
		end
		else
		begin
			readData_reg <= readData_next;
			readValid_reg <= readValid_next;
		end
	end

	assign readData = readData_reg;
	assign readValid = readValid_reg;

endmodule : thl_log_counters

/* thl_host_model.sv */
// Host side model issuing log page byte reads
`timescale 1ns/1ns
module thl_host_model(
	input wire logic ref_clk,
	input wire logic [7:0] readData,
	input wire logic readValid,
	output logic readStrobe,
	output logic [8:0] readByteAddr
);
	initial readStrobe = 1'b0;
	initial readByteAddr = 9'h000;
	// Released address is inverted so stale values never match
	task automatic readByte(input logic [8:0] a, output logic [8:0] r);
		@(negedge ref_clk);
		readStrobe = 1'b1;
		readByteAddr = a;
		@(negedge ref_clk);
		readStrobe = 1'b0;
		readByteAddr = ~a;
		r = {readValid, readData};
	endtask : readByte
endmodule : thl_host_model

/* thl_log_properties.sv */
// Checker of the read port and log page contents
`timescale 1ns/1ns
module thl_log_properties(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [95:0] sensorKelvin,
	input wire logic [5:0] sensorPresent,
	input wire logic counterEnable,
	input wire logic tmt1Active,
	input wire logic tmt2Active,
	input wire logic readStrobe,
	input wire logic [8:0] readByteAddr,
	input wire logic [7:0] readData,
	input wire logic readValid
);
	default clocking dc @(posedge ref_clk); endclocking
	default disable iff (srst);
	sequence rdAt(logic [8:0] a);
		readStrobe && readByteAddr == a;
	endsequence
	answer_next_a:
	assert property (readStrobe |=> readValid) else $error("read not answered");
	no_spurious_a:
	assert property (!readStrobe |=> !readValid && $stable(readData)) else $error("stray answer");
	sensor_low_a:
	assert property (rdAt(9'h0cc) ##0 sensorPresent[0] |=> readData == $past(sensorKelvin[7:0]))
		else $error("sensor low byte");
	sensor_high_a:
	assert property (rdAt(9'h0d5) ##0 sensorPresent[4] |=> readData == $past(sensorKelvin[79:72]))
		else $error("sensor high byte");
	absent_zero_a:
	assert property (rdAt(9'h0d6) ##0 !sensorPresent[5] |=> readData == 8'h00)
		else $error("absent sensor");
	reserved_zero_a:
	assert property (readStrobe && readByteAddr > 9'h0e7 |=> readData == 8'h00)
		else $error("reserved byte");
	unimpl_zero_a:
	assert property (readStrobe && readByteAddr > 9'h0d7 && !counterEnable && !$past(counterEnable)
		|=> readData == 8'h00) else $error("disabled counter");
	reset_clear_a:
	assert property (disable iff (1'b0) srst |=> readData == 8'h00 && !readValid)
		else $error("reset output");
endmodule : thl_log_properties

/* tb_top.sv */
// Bench reading the thermal tail of the health log page
`timescale 1ns/1ns
module tb_top;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic [95:0] sensorKelvin = '0;
	logic [5:0] sensorPresent = 6'h1f;
	logic counterEnable = 1'b1;
	logic tmt1Active = 1'b0;
	logic tmt2Active = 1'b0;
	logic readStrobe;
	logic [8:0] readByteAddr;
	logic [7:0] readData;
	logic readValid;
	int errTotal = 0;
	int numChecks = 0;
	always #10 ref_clk = ~ref_clk;
	localparam int TICK_CYCLES = 1000;
	thl_log_counters #(.TICK_LAST(26'(TICK_CYCLES - 1))) i_dut(.*);
	thl_host_model i_host(.*);
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		numChecks++;
		if (seen !== exp)
		begin
			errTotal++;
			$display("ERROR %0t read %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic expectByte(input int a, input logic [7:0] e);
		logic [8:0] r;
		i_host.readByte(9'(a), r);
		check(r, {1'b1, e});
	endtask : expectByte
	task automatic rise(ref logic s, input int len);
		@(negedge ref_clk);
		s = 1'b1;
		repeat (len) @(negedge ref_clk);
		s = 1'b0;
		@(negedge ref_clk);
	endtask : rise
	task automatic finalReport;
		if (errTotal == 0 && numChecks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finalReport
	initial
	begin
		for (int i = 0; i < 6; i++)
			sensorKelvin[i*16 +: 16] = 16'h0120 + 16'(i * 257);
		repeat (10) @(negedge ref_clk);
		srst = 1'b0;
		// Sensor eight absent; counters still untouched
		for (int a = 204; a < 232; a++)
			expectByte(a, a < 216 && sensorPresent[(a-204)/2] ? sensorKelvin[(a-204)*8 +: 8] : 8'h00);
		rise(tmt1Active, 3);
		rise(tmt1Active, 3);
		rise(tmt2Active, 3);
		expectByte(216, 8'h02);
		expectByte(217, 8'h00);
		expectByte(220, 8'h01);
		// Under one second elapsed, so times stay zero
		expectByte(224, 8'h00);
		expectByte(228, 8'h00);
		expectByte(232, 8'h00);
		expectByte(511, 8'h00);
		// A spell of n whole tick periods holds exactly n ticks
		rise(tmt1Active, 3 * TICK_CYCLES);
		rise(tmt2Active, 2 * TICK_CYCLES);
		expectByte(216, 8'h03);
		expectByte(220, 8'h02);
		expectByte(224, 8'h03);
		expectByte(225, 8'h00);
		expectByte(228, 8'h02);
		counterEnable = 1'b0;
		repeat (2) @(negedge ref_clk);
		expectByte(216, 8'h00);
		expectByte(224, 8'h00);
		expectByte(228, 8'h00);
		counterEnable = 1'b1;
		rise(tmt2Active, 3);
		expectByte(220, 8'h01);
		finalReport();
	end
	initial
	begin
		repeat (6 * TICK_CYCLES + 2000) @(posedge ref_clk);
		errTotal++;
		finalReport();
	end
endmodule : tb_top
bind thl_log_counters thl_log_properties i_chk(
	.ref_clk(ref_clk),
	.srst(srst),
	.sensorKelvin(sensorKelvin),
	.sensorPresent(sensorPresent),
	.counterEnable(counterEnable),
	.tmt1Active(tmt1Active),
	.tmt2Active(tmt2Active),
	.readStrobe(readStrobe),
	.readByteAddr(readByteAddr),
	.readData(readData),
	.readValid(readValid)
);
